// file: aoas_alarm_status.sv
// Alarm, status word, lamps and output safety control of the analog output module
// Behaviour
// - Any alarm lights unit lamp, sets its status bit
// - Word base is 2000 plus ten per unit
// - Out-of-range value applies hold setting; flags output only outside adjustment mode
// - Run-time flags clear when condition goes away
// - Store failure sets bit 14, freezes outputs
// - Bit 15 set throughout adjustment mode
// - Bad adjust channel sets bit 13, zero output
// - Host running in adjust: only bit 15, zero
// - Setting error flags stay until restart
// - Bad scaling limits set bit 8
// - Hold code above 2 sets bit 10
// - Timing or mode code above 1 sets bit 12
// - Run lamp dark when exchange stopped
// - Adjust lamp flashes only in adjustment mode
// - Bus or watchdog fault: host lamp, hold setting
// - Refresh timeout freezes outputs
// - Bad unit number or table gives zero
// - Outputs zero while restarting
`timescale 1ns/1ps
module aoas_alarm_status
  import aoas_pkg::*;
#(
  parameter int NCH      = 8,
  parameter int MON_CNT  = MON_CYCLES,
  parameter int BLINK_CNT = BLINK_CYCLES
)(
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  // Front-panel switches (pins)
  input  wire logic [6:0]           unitNumPin,
  input  wire logic                 adjModePin,
  // Host bus condition
  input  wire logic                 ioRefresh,
  input  wire logic [1:0]           hostMode,
  input  wire logic                 busErr,
  input  wire logic                 hostWdtErr,
  input  wire logic                 dupUnit,
  input  wire logic                 tableMismatch,
  input  wire logic                 restartBit,
  // Host word access
  input  wire logic [15:0]          hostRdAddr,
  output logic      [15:0]          hostRdData_r,
  output logic      [15:0]          wordBase_r,
  output logic      [15:0]          statusWord_r,
  // Settings
  input  wire logic [15:0]          scaleUpper,
  input  wire logic [15:0]          scaleLower,
  input  wire logic [15:0]          holdSetting,
  input  wire logic [7:0]           convCode,
  input  wire logic [7:0]           opModeCode,
  input  wire logic [NCH-1:0]       chanEnable,
  // Adjustment
  input  wire logic [7:0]           adjChannel,
  input  wire logic                 storeReq,
  input  wire logic                 storeFail,
  // Analog data
  input  wire logic [NCH-1:0][15:0] setValue,
  output logic      [NCH-1:0][15:0] dacOut,
  // Lamps
  output logic                      runLamp_r,
  output logic                      unit_fault_lamp_r,
  output logic                      host_fault_lamp_r,
  output logic                      calibrate_lamp
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [7:0]  pinMeta_r;
  logic [7:0]  pinSync_r;
  logic [6:0]  unitNum;
  logic        adjMode;

  // Switches are asynchronous; second stage is the only reader of the first
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      pinMeta_r <= 8'h00;
      pinSync_r <= 8'h00;
    end
    else
    begin
      pinMeta_r <= {adjModePin, unitNumPin};
      pinSync_r <= pinMeta_r;
    end
  assign unitNum = pinSync_r[6:0];
  assign adjMode = pinSync_r[7];

  // ****************************************************************
  // Condition decode
  // ****************************************************************
  aoas_state_t state_r;
  aoas_state_t state_nxt;
  logic        plcErr;
  logic        unitBad;
  logic        chanBad;
  logic [7:0]  chanIdx;
  logic        scaleErr;
  logic        holdErr;
  logic        convErr;
  logic [31:0] monCnt_r;
  logic        monTimeout;
  logic        storeReqPrev_r;
  logic        storeErr_r;
  logic [2:0]  initFlags_r;
  logic [NCH-1:0] rangeErr;
  logic [15:0] statusNxt;

  assign plcErr  = adjMode && (hostMode != HOST_PROGRAM);
  assign unitBad = (unitNum > UNIT_NUM_MAX) || dupUnit || tableMismatch;
  assign chanIdx = adjChannel - ADJ_CH_FIRST;
  assign chanBad = adjMode && !plcErr &&
                   ((adjChannel < ADJ_CH_FIRST) || (adjChannel > ADJ_CH_LAST) ||
                    (chanIdx >= 8'(NCH)) || !chanEnable[chanIdx[2:0]]);
  assign scaleErr = (scaleUpper > SCALE_LIMIT_MAX) || (scaleLower > SCALE_LIMIT_MAX) ||
                    ((scaleUpper == scaleLower) && (scaleUpper != 16'h0000));
  assign holdErr  = holdSetting > HOLD_CODE_MAX;
  assign convErr  = (convCode > MODE_CODE_MAX) || (opModeCode > MODE_CODE_MAX);

  // Refresh watchdog; saturates so a dead host stays detected
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      monCnt_r <= 32'h0;
    else if (ioRefresh)
      monCnt_r <= 32'h0;
    else if (monCnt_r < 32'(MON_CNT))
      monCnt_r <= monCnt_r + 32'h1;
  assign monTimeout = (monCnt_r >= 32'(MON_CNT));

  // ****************************************************************
  // Start-up and restart sequence
  // ****************************************************************
  // Settings are judged once per restart so their flags cannot flicker
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_RESTART: if (!restartBit) state_nxt = ST_CHECK;
      ST_CHECK:   state_nxt = (scaleErr || holdErr || convErr) ? ST_STOP : ST_RUN;
      ST_RUN:     if (restartBit) state_nxt = ST_RESTART;
      ST_STOP:    if (restartBit) state_nxt = ST_RESTART;
      default:    state_nxt = ST_RESTART;
    endcase
  end
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      state_r <= ST_RESTART;
    else
      state_r <= state_nxt;
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      initFlags_r <= 3'b000;
    else if (state_r == ST_CHECK)
      initFlags_r <= {convErr, holdErr, scaleErr};

  // store failure flag, set wins over clear
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      storeErr_r     <= 1'b0;
      storeReqPrev_r <= 1'b0;
    end
    else
    begin
      storeReqPrev_r <= storeReq;
      if (storeFail && adjMode)
        storeErr_r <= 1'b1;
      else if ((storeReq && !storeReqPrev_r) || !adjMode)
        storeErr_r <= 1'b0;
    end

  // ****************************************************************
  // Status word
  // ****************************************************************
  // Run-time bits are recomputed each cycle, so they clear themselves
  // run bits self-clear
  always_comb
  begin
    statusNxt = STATUS_RESET;
    if (plcErr)
      statusNxt = STATUS_PLC_ERR;
    else
    begin
      if (state_r == ST_RUN && !adjMode)
        statusNxt[SETERR_LSB +: SETERR_W] = SETERR_W'(rangeErr);
      statusNxt[SCALE_ERR_B] = initFlags_r[0];
      statusNxt[HOLD_ERR_B]  = initFlags_r[1];
      statusNxt[CONV_ERR_B]  = initFlags_r[2];
      statusNxt[CHAN_ERR_B]  = chanBad;
      statusNxt[STORE_ERR_B] = storeErr_r;
      statusNxt[ADJ_ON_B]    = adjMode;
    end
  end
  // status always current, host polls freely
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      statusWord_r <= STATUS_RESET;
    else
      statusWord_r <= statusNxt;

  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      wordBase_r <= WORD_AREA_BASE;
    else
      wordBase_r <= WORD_AREA_BASE + 16'(unitNum) * WORDS_PER_UNIT;

  // Host word read; other words of the block read as zero
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      hostRdData_r <= 16'h0000;
    else if (hostRdAddr == wordBase_r + ALARM_STATUS_OFS)
      hostRdData_r <= statusWord_r;
    else
      hostRdData_r <= 16'h0000;

  // ****************************************************************
  // Lamps
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      runLamp_r         <= 1'b0;
      unit_fault_lamp_r <= 1'b0;
      host_fault_lamp_r <= 1'b0;
    end
    else
    begin
      runLamp_r         <= (state_r == ST_RUN) && !plcErr && !unitBad;
      unit_fault_lamp_r <= (|statusNxt[14:0]) || plcErr;
      host_fault_lamp_r <= busErr || hostWdtErr || monTimeout || unitBad;
    end

  aoas_blink #(.HALF(BLINK_CNT)) uBlink (
    .clk    (clk),
    .rst_b  (rst_b),
    .en     (adjMode),
    .lamp_r (calibrate_lamp)
  );

  // ****************************************************************
  // Output control
  // ****************************************************************
  aoas_ctl_if ctl ();
  assign ctl.holdSel = aoas_hold_t'(holdSetting[1:0]);
  // Priority: safety zero, then freeze on silence, then hold function
  always_comb
  begin
    ctl.mode = CH_PASS;
    if (state_r != ST_RUN || unitBad || plcErr)
      ctl.mode = CH_ZERO;
    else if (monTimeout)
      ctl.mode = CH_FREEZE;
    else if (busErr || hostWdtErr)
      ctl.mode = CH_HOLDFN;
    else if (chanBad)
      ctl.mode = CH_ZERO;
    else if (storeErr_r)
      ctl.mode = CH_FREEZE;
  end

  // One channel per output
  for (genvar i = 0; i < NCH; i++)
  begin : gChan
    aoas_chan #(.MAXV(SET_VALUE_MAX)) uChan (
      .clk      (clk),
      .rst_b    (rst_b),
      .ctl      (ctl.chan),
      .cmd      (setValue[i]),
      .en       (chanEnable[i]),
      .outVal_r (dacOut[i]),
      .rangeErr (rangeErr[i])
    );
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  adj_flag_a: assert property (!plcErr |=> statusWord_r[ADJ_ON_B] == $past(adjMode))
    else $error("adjust flag wrong");
  plc_only_a: assert property (plcErr |=> statusWord_r == STATUS_PLC_ERR && dacOut == '0)
    else $error("host clash status wrong");
  alarm_lamp_a: assert property (|statusNxt[14:0] |=> unit_fault_lamp_r)
    else $error("unit lamp not lit");
  base_word_a: assert property ($stable(unitNum) [*2] |-> wordBase_r == 16'd2000 + 16'(unitNum) * 16'd10)
    else $error("base word wrong");
  setval_flag_a: assert property (state_r == ST_RUN && !adjMode && !plcErr && rangeErr[0]
                                  |=> statusWord_r[0])
    else $error("set value flag missing");
  self_clear_a: assert property (!plcErr && !rangeErr[0] |=> !statusWord_r[0])
    else $error("run flag stuck");
  store_err_a: assert property (storeFail && adjMode |=> storeErr_r ##1 $stable(dacOut) || !storeErr_r)
    else $error("store failure not held");
  chan_err_a: assert property (chanBad && state_r == ST_RUN && !monTimeout && !busErr && !hostWdtErr && !unitBad
                               |=> statusWord_r[13] && dacOut == '0)
    else $error("channel error handling wrong");
  init_hold_a: assert property (state_r == ST_STOP && !restartBit |=> state_r == ST_STOP && $stable(initFlags_r))
    else $error("setting flags released early");
  stop_run_a: assert property (state_r == ST_STOP |=> !runLamp_r)
    else $error("run lamp lit while stopped");
  host_lamp_a: assert property (busErr || hostWdtErr || unitBad |=> host_fault_lamp_r)
    else $error("host lamp not lit");
  freeze_a: assert property (state_r == ST_RUN && monTimeout && !unitBad && !plcErr |=> $stable(dacOut))
    else $error("outputs moved after timeout");
  restart_zero_a: assert property (state_r == ST_RESTART |=> dacOut == '0)
    else $error("outputs not zero in restart");
  cv_run_c:     cover property (state_r == ST_CHECK ##1 state_r == ST_RUN);
  cv_stop_c:    cover property (state_r == ST_CHECK ##1 state_r == ST_STOP);
  cv_store_c:   cover property (storeErr_r ##1 !storeErr_r);
  cv_timeout_c: cover property (monTimeout && state_r == ST_RUN);
endmodule : aoas_alarm_status

// file: aoas_alarm_status_tb_top.sv
// Self-checking bench for the analog output alarm and status block
`timescale 1ns/1ps
module aoas_alarm_status_tb_top;
  import aoas_pkg::*;
  typedef struct {int sel; logic [15:0] exp;} aoas_note_t;
  logic             clk = 1'b0, rst_b = 1'b0, refreshOn = 1'b1, restartReq = 1'b0;
  logic             ioRefresh, restartBit, adjModePin = 1'b0, busErr = 1'b0, hostWdtErr = 1'b0;
  logic             dupUnit = 1'b0, tableMismatch = 1'b0, storeReq = 1'b0, storeFail = 1'b0;
  logic [6:0]       unitNumPin  = 7'h05;
  logic [1:0]       hostMode    = HOST_RUN;
  logic [15:0]      hostRdAddr  = 16'd2059, scaleUpper = 16'h0000, scaleLower = 16'h0000;
  logic [15:0]      holdSetting = 16'h0000, hostRdData_r, wordBase_r, statusWord_r, lampChg;
  logic [7:0]       convCode = 8'h00, opModeCode = 8'h00, chanEnable = 8'hff, adjChannel = 8'h11;
  logic [7:0][15:0] setValue, dacOut;
  logic             runLamp, unitFault, hostFault, calLamp, prevLamp;
  logic [15:0]      errBit [5] = '{16'h0100, 16'h0400, 16'h1000, 16'h1000, 16'h0100};
  aoas_note_t       noteQ [$];
  aoas_note_t       nt;
  event             noteEv;
  int               seed = 55, badCount = 0, cmpCount = 0, cycCnt = 0;

  always #50 clk = ~clk;

  aoas_host_model #(.PERIOD(10)) aoas_host_model_inst (.clk(clk), .rst_b(rst_b),
    .refreshOn(refreshOn), .restartReq(restartReq), .ioRefresh(ioRefresh), .restartBit(restartBit));

  aoas_alarm_status #(.NCH(8), .MON_CNT(50), .BLINK_CNT(4)) aoas_alarm_status_inst (
    .clk(clk), .rst_b(rst_b), .unitNumPin(unitNumPin), .adjModePin(adjModePin),
    .ioRefresh(ioRefresh), .hostMode(hostMode), .busErr(busErr), .hostWdtErr(hostWdtErr),
    .dupUnit(dupUnit), .tableMismatch(tableMismatch), .restartBit(restartBit),
    .hostRdAddr(hostRdAddr), .hostRdData_r(hostRdData_r), .wordBase_r(wordBase_r),
    .statusWord_r(statusWord_r), .scaleUpper(scaleUpper), .scaleLower(scaleLower),
    .holdSetting(holdSetting), .convCode(convCode), .opModeCode(opModeCode),
    .chanEnable(chanEnable), .adjChannel(adjChannel), .storeReq(storeReq),
    .storeFail(storeFail), .setValue(setValue), .dacOut(dacOut), .runLamp_r(runLamp),
    .unit_fault_lamp_r(unitFault), .host_fault_lamp_r(hostFault), .calibrate_lamp(calLamp));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    cmpCount++;
    if (seen !== want)
    begin
      badCount++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic note_exp(input int sel, input logic [15:0] exp);
    noteQ.push_back('{sel, exp});
    -> noteEv;
  endtask : note_exp

  // Pulse the restart bit; output 0 is checked once for zero meanwhile
  task automatic restart();
    restartReq = 1'b1;
    tick(1);
    restartReq = 1'b0;
    tick(2);
    note_exp(1, 16'h0000);
    tick(8);
  endtask : restart

  task automatic completeRun();
    if (noteQ.size() != 0)
      badCount++;
    $display("compares %0d mismatches %0d", cmpCount, badCount);
    if (badCount == 0 && cmpCount > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : completeRun

  function automatic logic [15:0] observe(input int sel);
    case (sel)
      0: return statusWord_r;
      1: return dacOut[0];
      2: return {13'h0000, runLamp, unitFault, hostFault};
      3: return hostRdData_r;
      4: return wordBase_r;
      5: return {15'h0000, calLamp};
      7: return dacOut[7];
      default: return lampChg;
    endcase
  endfunction : observe

  // Watcher: oldest note against what the outputs show now
  always @(noteEv)
    while (noteQ.size() > 0)
    begin
      nt = noteQ.pop_front();
      check(observe(nt.sel), nt.exp);
    end

  // Hang guard, far above the few hundred cycles needed
  always @(posedge clk)
  begin
    cycCnt++;
    if (cycCnt == 20000)
    begin
      badCount++;
      completeRun();
    end
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    for (int i = 0; i < 8; i++)
      setValue[i] = 16'($unsigned($random(seed)) % 32'h0000_1069);
    tick(2);
    rst_b = 1'b1;
    tick(8);
    note_exp(4, 16'd2050);
    note_exp(7, setValue[7]);
    note_exp(2, 16'h0004);
    for (int i = 0; i < 4; i++)
    begin
      setValue[0] = (i == 3) ? SET_VALUE_MAX : 16'($unsigned($random(seed)) % 32'h0000_1069);
      tick(2);
      note_exp(1, setValue[0]);
    end
    for (int h = 0; h < 3; h++)
    begin
      holdSetting = 16'(h);
      restart();
      setValue[0] = 16'h0100;
      tick(3);
      setValue[0] = SET_VALUE_MAX + 16'h0001;
      tick(3);
      note_exp(0, 16'h0001);
      note_exp(2, 16'h0006);
      note_exp(3, 16'h0001);
      note_exp(1, (h == 0) ? 16'h0000 : ((h == 1) ? 16'h0100 : SET_VALUE_MAX));
      setValue[0] = 16'h0200;
      tick(3);
      note_exp(0, 16'h0000);
      note_exp(2, 16'h0004);
    end
    setValue[0] = 16'h1069;
    hostRdAddr = 16'd2058;
    tick(3);
    note_exp(3, 16'h0000);
    hostRdAddr = 16'd2059;
    for (int k = 0; k < 5; k++)
    begin
      case (k)
        0: scaleLower = 16'h0010;
        1: holdSetting = 16'h0003;
        2: convCode = 8'h02;
        3: opModeCode = 8'h02;
        default: scaleUpper = 16'h8000;
      endcase
      scaleUpper = (k == 0) ? 16'h0010 : scaleUpper;
      restart();
      note_exp(0, errBit[k]);
      note_exp(2, 16'h0002);
      {scaleUpper, scaleLower, holdSetting, convCode, opModeCode} = {16'h0000, 16'h0000, 16'h0001, 8'h00, 8'h00};
      setValue[0] = 16'h0300;
      tick(3);
      note_exp(0, errBit[k]);
      restart();
      note_exp(0, 16'h0000);
    end
    for (int k = 0; k < 2; k++)
    begin
      busErr = (k == 0);
      hostWdtErr = (k == 1);
      setValue[0] = 16'h0400;
      tick(3);
      note_exp(2, 16'h0005);
      note_exp(1, 16'h0300);
      {busErr, hostWdtErr} = 2'b00;
      setValue[0] = 16'h0300;
      restart();
    end
    refreshOn = 1'b0;
    tick(60);
    setValue[0] = 16'h0500;
    tick(3);
    note_exp(1, 16'h0300);
    refreshOn = 1'b1;
    restart();
    for (int k = 0; k < 3; k++)
    begin
      dupUnit = (k == 0);
      tableMismatch = (k == 1);
      unitNumPin = (k == 2) ? 7'h60 : 7'h05;
      tick(4);
      note_exp(1, 16'h0000);
      note_exp(2, 16'h0001);
      {dupUnit, tableMismatch, unitNumPin} = {2'b00, 7'h05};
      restart();
    end
    adjModePin = 1'b1;
    hostMode = HOST_PROGRAM;
    restart();
    note_exp(0, 16'h8000);
    lampChg = 16'h0000;
    for (int i = 0; i < 16; i++)
    begin
      prevLamp = calLamp;
      tick(1);
      lampChg = lampChg + ((calLamp !== prevLamp) ? 16'h0001 : 16'h0000);
    end
    note_exp(6, 16'h0004);
    for (int k = 0; k < 2; k++)
    begin
      adjChannel = (k == 0) ? 8'h15 : 8'h12;
      chanEnable = 8'hfd;
      tick(3);
      note_exp(0, 16'ha000);
      note_exp(1, 16'h0000);
      note_exp(2, 16'h0006);
    end
    {chanEnable, adjChannel} = {8'hff, 8'h11};
    storeFail = 1'b1;
    tick(1);
    storeFail = 1'b0;
    tick(3);
    note_exp(0, 16'hc000);
    storeReq = 1'b1;
    tick(2);
    storeReq = 1'b0;
    tick(3);
    note_exp(0, 16'h8000);
    for (int k = 1; k < 3; k++)
    begin
      hostMode = 2'(k);
      tick(3);
      note_exp(0, STATUS_PLC_ERR);
      note_exp(1, 16'h0000);
    end
    adjModePin = 1'b0;
    restart();
    note_exp(0, 16'h0000);
    note_exp(5, 16'h0000);
    tick(2);
    completeRun();
  end
endmodule : aoas_alarm_status_tb_top

// file: aoas_blink.sv
// Lamp flasher: square wave while enabled, dark otherwise
`timescale 1ns/1ps
module aoas_blink #(
  parameter int HALF = 2_500_000
)(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Lamp
  input  wire logic en,
  output logic      lamp_r
);

  logic [31:0] cnt_r;

  // Half-period counter and lamp toggle
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      cnt_r  <= 32'h0;
      lamp_r <= 1'b0;
    end
    else if (!en)
    begin
      cnt_r  <= 32'h0;
      lamp_r <= 1'b0;
    end
    else if (cnt_r >= 32'(HALF - 1))
    begin
      cnt_r  <= 32'h0;
      lamp_r <= ~lamp_r;
    end
    else
      cnt_r <= cnt_r + 32'h1;

endmodule : aoas_blink

// file: aoas_chan.sv
// One analog output channel: range check and output value selection
`timescale 1ns/1ps
module aoas_chan
  import aoas_pkg::*;
#(
  parameter logic [15:0] MAXV = SET_VALUE_MAX
)(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  // Control
  aoas_ctl_if.chan          ctl,
  // Data
  input  wire logic [15:0]  cmd,
  input  wire logic         en,
  output logic      [15:0]  outVal_r,
  output logic              rangeErr
);

  // Live range check, no memory so it clears itself
  assign rangeErr = en && (cmd > MAXV);

  // Output selection; frozen value is simply the register left alone
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      outVal_r <= 16'h0000;
    else
    begin
      case (ctl.mode)
        CH_ZERO:   outVal_r <= 16'h0000;
        CH_FREEZE: outVal_r <= outVal_r;
        default:
        begin
          if (!en)
            outVal_r <= 16'h0000;
          else if (ctl.mode == CH_HOLDFN || rangeErr)
          begin
            case (ctl.holdSel)
              HOLD_LAST: outVal_r <= outVal_r;
              HOLD_MAX:  outVal_r <= MAXV;
              default:   outVal_r <= 16'h0000;
            endcase
          end
          else
            outVal_r <= cmd;
        end
      endcase
    end

endmodule : aoas_chan

// file: aoas_ctl_if.sv
// Output control shared by the sequencer and every output channel
`timescale 1ns/1ps
interface aoas_ctl_if;
  import aoas_pkg::*;
  aoas_chmode_t mode;
  aoas_hold_t   holdSel;
  modport drv  (output mode, output holdSel);
  modport chan (input mode, input holdSel);
endinterface : aoas_ctl_if

// file: aoas_host_model.sv
// Host processor model: cyclic refresh pulses and restart bit
`timescale 1ns/1ps
module aoas_host_model #(
  parameter int PERIOD = 10
)(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Bench requests
  input  wire logic refreshOn,
  input  wire logic restartReq,
  // Host bus
  output logic      ioRefresh,
  output logic      restartBit
);
  int refCnt;
  int rstCnt;
  // Refresh every PERIOD cycles, kept well inside the monitoring period
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      refCnt    <= 0;
      ioRefresh <= 1'b0;
    end
    else
    begin
      refCnt    <= (refCnt == PERIOD - 1) ? 0 : refCnt + 1;
      ioRefresh <= refreshOn && (refCnt == 0);
    end
  end
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rstCnt     <= 0;
      restartBit <= 1'b0;
    end
    else if (restartReq)
    begin
      rstCnt     <= 4;     // Bit held four cycles
      restartBit <= 1'b1;
    end
    else if (rstCnt > 1)
      rstCnt <= rstCnt - 1;
    else
    begin
      rstCnt     <= 0;
      restartBit <= 1'b0;
    end
  end
endmodule : aoas_host_model

// file: aoas_pkg.sv
// Shared constants and types for the analog output alarm and status block
package aoas_pkg;

  // ****************************************************************
  // Host word area
  // ****************************************************************
  localparam logic [15:0] WORD_AREA_BASE    = 16'd2000;  // Base of the module word block
  localparam logic [15:0] WORDS_PER_UNIT    = 16'd10;    // Words given to each unit
  localparam logic [15:0] ALARM_STATUS_OFS  = 16'h0009;  // Status word offset from the base
  localparam logic [6:0]  UNIT_NUM_MAX      = 7'd95;     // Highest legal unit number

  // ****************************************************************
  // Status word field positions
  // ****************************************************************
  localparam int SETERR_LSB   = 0;   // Per-output set-value errors, bits 0..7
  localparam int SETERR_W     = 8;
  localparam int SCALE_ERR_B  = 8;
  localparam int HOLD_ERR_B   = 10;
  localparam int CONV_ERR_B   = 12;
  localparam int CHAN_ERR_B   = 13;
  localparam int STORE_ERR_B  = 14;
  localparam int ADJ_ON_B     = 15;
  localparam logic [15:0] STATUS_RESET   = 16'h0000;
  localparam logic [15:0] STATUS_PLC_ERR = 16'h8000;   // Only the adjustment flag set

  // ****************************************************************
  // Setting codes and limits
  // ****************************************************************
  localparam logic [15:0] HOLD_CODE_MAX   = 16'h0002;  // Legal hold codes 0..2
  localparam logic [7:0]  MODE_CODE_MAX   = 8'h01;     // Legal timing and mode codes 0..1
  localparam logic [15:0] SCALE_LIMIT_MAX = 16'h7fff;  // Largest legal scaling limit
  localparam logic [15:0] SET_VALUE_MAX   = 16'h1068;  // Largest legal commanded value
  localparam logic [7:0]  ADJ_CH_FIRST    = 8'h11;     // Adjustment channel codes 11..14
  localparam logic [7:0]  ADJ_CH_LAST     = 8'h14;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_FREQ_HZ   = 10_000_000;
  localparam int MON_TIME_MS   = 100;   // Host refresh monitoring period
  localparam int BLINK_HALF_MS = 250;   // Half period of the adjust lamp flash
  localparam int MON_CYCLES    = MON_TIME_MS * (CLK_FREQ_HZ / 1000);
  localparam int BLINK_CYCLES  = BLINK_HALF_MS * (CLK_FREQ_HZ / 1000);

  // ****************************************************************
  // Enumerations
  // ****************************************************************
  typedef enum logic [1:0] {
    HOST_PROGRAM = 2'b00,
    HOST_MONITOR = 2'b01,
    HOST_RUN     = 2'b10
  } aoas_hostmode_t;

  typedef enum logic [1:0] {
    HOLD_CLEAR = 2'b00,   // Output goes to zero
    HOLD_LAST  = 2'b01,   // Output keeps its last value
    HOLD_MAX   = 2'b10    // Output goes to full scale
  } aoas_hold_t;

  typedef enum logic [1:0] {
    CH_PASS   = 2'b00,
    CH_ZERO   = 2'b01,
    CH_FREEZE = 2'b10,
    CH_HOLDFN = 2'b11
  } aoas_chmode_t;

  typedef enum logic [1:0] {
    ST_RESTART = 2'b00,
    ST_CHECK   = 2'b01,
    ST_RUN     = 2'b10,
    ST_STOP    = 2'b11
  } aoas_state_t;

endpackage : aoas_pkg
